// ==== rtl/sgp_params.svh ====
// Purpose: offsets, field positions, reset values and timing counts for sgp
// Assumes: 20 MHz system clock
// Notes: included by the sleep timer and control modules, not by the package
`ifndef SGP_PARAMS_SVH
`define SGP_PARAMS_SVH
`define SGP_OFS_GLOBAL_CONTROL_NINE 8'h0b
`define SGP_OFS_GLOBAL_CONTROL_TEN  8'h0c
`define SGP_OFS_FACTORY_TEST_ELEVEN 8'h0d
`define SGP_OFS_POWER_MODE_CONTROL  8'h0e
`define SGP_OFS_SLEEP_DELAY_CONTROL 8'h0f
`define SGP_BIT_READ_EDGE           0
`define SGP_BIT_TRAILER_EN          1
`define SGP_BIT_PASS_FLOW           0
`define SGP_BIT_PLL_DOWN            5
`define SGP_MODE_LSB                3
`define SGP_TEN_RESERVED            8'h44
`define SGP_FACTORY_VALUE           8'h00
`define SGP_SLEEP_RESET             8'h50
`define SGP_MODE_NORMAL             2'h0
`define SGP_MODE_ENERGY             2'h1
`define SGP_MODE_SOFT_DOWN          2'h2
`define SGP_UNIT_MS                 20
`define SGP_CLOCK_KHZ               20000
`define SGP_UNIT_CYCLES             (`SGP_UNIT_MS * `SGP_CLOCK_KHZ)
`define SGP_TRAILER_PORT            3'h4
`endif

// ==== rtl/sgp_pkg.sv ====
// Purpose: types shared by the sgp modules
// Assumes: nothing
// Notes: constants live in sgp_params.svh
package sgp_pkg;
    typedef enum logic [1:0] {
        normal_power_state,
        energy_detect_state,
        soft_power_down_state,
        reserved_state
    } sgp_mode_type;

    typedef struct packed {
        logic       read_edge_rising;
        logic       trailer_enable;
        logic       pass_flow_control;
        logic       pll_down_enable;
        logic [1:0] mode;
        logic [7:0] sleep_delay;
    } sgp_regs_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } sgp_access_type;

    typedef struct packed {
        logic        running;
        logic        asleep;
        logic [7:0]  units;
        logic [31:0] cycles;
    } sgp_timer_type;
endpackage : sgp_pkg

// ==== rtl/sgp_sleep_timer.sv ====
// Purpose: counts consecutive no-energy time in 20 ms units
// Assumes: no_energy is synchronous to clock
// Notes: unit length is a parameter so simulation can shorten it
`timescale 1ns/1ps
`include "sgp_params.svh"
module sgp_sleep_timer #(
    parameter int unsigned UNIT_CYCLES = `SGP_UNIT_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       active,
    input  wire logic       no_energy,
    input  wire logic [7:0] delay_units,
    output logic            asleep
);
    // a zero unit length would never reach its last count
    if (UNIT_CYCLES < 1) begin : g_bad_unit
        $error("sgp_sleep_timer: UNIT_CYCLES must be at least 1");
    end

    localparam logic [31:0] UNIT_LAST = 32'(UNIT_CYCLES - 1);

    sgp_pkg::sgp_timer_type st;
    sgp_pkg::sgp_timer_type next_st;

    always_comb begin
        next_st = st;
        if (!active || !no_energy) begin
            // any energy restarts the consecutive count
            next_st = '0;
        end else if (!st.asleep) begin
            if (st.units >= delay_units) begin
                next_st.asleep = 1'b1;
            end else if (st.cycles == UNIT_LAST) begin
                next_st.cycles = '0;
                next_st.units  = st.units + 8'h01;
            end else begin
                next_st.cycles = st.cycles + 32'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign asleep = st.asleep;

    AST_WAKE_ON_ENERGY: assert property (@(posedge clock) disable iff (rst)
        (!no_energy && active) |=> !asleep)
        else $error("sleep held although energy was seen");
    AST_SLEEP_NEEDS_COUNT: assert property (@(posedge clock) disable iff (rst)
        $rose(asleep) |-> $past(st.units) >= $past(delay_units))
        else $error("sleep entered before the delay elapsed");
endmodule : sgp_sleep_timer

// ==== rtl/sgp_switch_global_power_control.sv ====
// Purpose: global and power-management control registers of the switch
// Assumes: register access strobes come from the serial management port
// Notes: read data is registered and valid the cycle after read
`timescale 1ns/1ps
`include "sgp_params.svh"
module sgp_switch_global_power_control #(
    parameter int unsigned UNIT_CYCLES = `SGP_UNIT_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic [2:0] egress_port,
    input  wire logic       no_energy,
    output logic            read_edge_rising,
    output logic            trailer_insert,
    output logic            pass_flow_control,
    output logic            pll_power_down,
    output logic            energy_detect_power_down,
    output logic            soft_power_down,
    output logic            low_power
);
    // a zero unit length could never be counted out by the sleep timer
    if (UNIT_CYCLES < 1) begin : g_bad_unit
        $error("sgp: UNIT_CYCLES must be at least 1");
    end

    typedef struct packed {
        sgp_pkg::sgp_regs_type regs;
        logic [7:0]            rdata;
    } sgp_state_type;

    sgp_state_type st;
    sgp_state_type next_st;
    logic          asleep;

    function automatic logic [7:0] read_mux(input sgp_pkg::sgp_regs_type r,
                                            input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `SGP_OFS_GLOBAL_CONTROL_NINE: v = {7'h00, r.read_edge_rising};
            `SGP_OFS_GLOBAL_CONTROL_TEN:
                v = `SGP_TEN_RESERVED | {6'h00, r.trailer_enable, r.pass_flow_control};
            `SGP_OFS_FACTORY_TEST_ELEVEN: v = `SGP_FACTORY_VALUE;
            `SGP_OFS_POWER_MODE_CONTROL:
                v = {2'h0, r.pll_down_enable, r.mode, 3'h0};
            `SGP_OFS_SLEEP_DELAY_CONTROL: v = r.sleep_delay;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    always_comb begin
        next_st = st;
        if (reg_read) begin
            next_st.rdata = read_mux(st.regs, reg_addr);
            if (reg_addr == `SGP_OFS_POWER_MODE_CONTROL) begin
                next_st.regs.mode = `SGP_MODE_NORMAL;
            end
        end
        if (reg_write) begin
            case (reg_addr)
                `SGP_OFS_GLOBAL_CONTROL_NINE: begin
                    next_st.regs.read_edge_rising = reg_wdata[`SGP_BIT_READ_EDGE];
                end
                `SGP_OFS_GLOBAL_CONTROL_TEN: begin
                    next_st.regs.trailer_enable    = reg_wdata[`SGP_BIT_TRAILER_EN];
                    next_st.regs.pass_flow_control = reg_wdata[`SGP_BIT_PASS_FLOW];
                end
                `SGP_OFS_POWER_MODE_CONTROL: begin
                    next_st.regs.pll_down_enable = reg_wdata[`SGP_BIT_PLL_DOWN];
                    // a write in the same cycle as a read wins over the clear
                    next_st.regs.mode = reg_wdata[`SGP_MODE_LSB +: 2];
                end
                `SGP_OFS_SLEEP_DELAY_CONTROL: begin
                    next_st.regs.sleep_delay = reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st                  <= '0;
            st.regs.sleep_delay <= `SGP_SLEEP_RESET;
        end else begin
            st <= next_st;
        end
    end

    sgp_sleep_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_timer (
        .clock       (clock),
        .rst         (rst),
        .active      (energy_detect_power_down),
        .no_energy   (no_energy),
        .delay_units (st.regs.sleep_delay),
        .asleep      (asleep)
    );

    assign reg_rdata                = st.rdata;
    assign read_edge_rising         = st.regs.read_edge_rising;
    assign pass_flow_control        = st.regs.pass_flow_control;
    // gated by port so no other egress port ever gets the extra byte
    assign trailer_insert           = st.regs.trailer_enable
                                      && (egress_port == `SGP_TRAILER_PORT);
    // reserved encoding behaves as normal operation
    assign energy_detect_power_down = (st.regs.mode == `SGP_MODE_ENERGY);
    assign soft_power_down          = (st.regs.mode == `SGP_MODE_SOFT_DOWN);
    assign low_power                = asleep;
    assign pll_power_down           = st.regs.pll_down_enable && energy_detect_power_down
                                      && asleep;

    // any read of the mode register
    sequence seq_mode_read;
        reg_read && reg_addr == `SGP_OFS_POWER_MODE_CONTROL;
    endsequence

    // any write of the mode register, with or without a read beside it
    sequence seq_mode_write;
        reg_write && reg_addr == `SGP_OFS_POWER_MODE_CONTROL;
    endsequence

    // a read alone clears; a write in the same cycle must win
    sequence seq_mode_read_only;
        reg_read && !reg_write && reg_addr == `SGP_OFS_POWER_MODE_CONTROL;
    endsequence

    // low power seen rising, ending one cycle after the entry edge
    sequence seq_sleep_entry;
        !low_power ##1 low_power;
    endsequence

    AST_TRAILER_PORT_ONLY: assert property (@(posedge clock) disable iff (rst)
        trailer_insert |-> egress_port == `SGP_TRAILER_PORT)
        else $error("trailer byte on wrong port");
    AST_TRAILER_NEEDS_EN: assert property (@(posedge clock) disable iff (rst)
        trailer_insert |-> st.regs.trailer_enable)
        else $error("trailer inserted while disabled");
    AST_TRAILER_ON_PORT: assert property (@(posedge clock) disable iff (rst)
        (st.regs.trailer_enable && egress_port == `SGP_TRAILER_PORT) |-> trailer_insert)
        else $error("trailer missing on the uplink port");
    AST_TRAILER_STORE: assert property (@(posedge clock) disable iff (rst)
        (reg_write && reg_addr == `SGP_OFS_GLOBAL_CONTROL_TEN)
        |=> st.regs.trailer_enable == $past(reg_wdata[`SGP_BIT_TRAILER_EN]))
        else $error("trailer enable not stored");

    AST_MODE_READ_CLEAR: assert property (@(posedge clock) disable iff (rst)
        seq_mode_read_only |=> !energy_detect_power_down && !soft_power_down
        && st.regs.mode == `SGP_MODE_NORMAL)
        else $error("mode not cleared by read");
    AST_MODE_READ_VALUE: assert property (@(posedge clock) disable iff (rst)
        seq_mode_read |=> reg_rdata[`SGP_MODE_LSB +: 2] == $past(st.regs.mode))
        else $error("mode read returned wrong value");
    AST_WRITE_WINS_CLEAR: assert property (@(posedge clock) disable iff (rst)
        seq_mode_write |=> st.regs.mode == $past(reg_wdata[`SGP_MODE_LSB +: 2]))
        else $error("mode write lost against the read clear");
    AST_RDATA_HOLDS: assert property (@(posedge clock) disable iff (rst)
        !reg_read |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_MODE_HOLDS_IDLE: assert property (@(posedge clock) disable iff (rst)
        (!reg_read && !reg_write) |=> $stable(st.regs.mode))
        else $error("mode changed without an access");

    AST_PLL_ONLY_ENERGY: assert property (@(posedge clock) disable iff (rst)
        pll_power_down |-> energy_detect_power_down)
        else $error("pll down outside energy detect");
    AST_PLL_HELD_CLEAR: assert property (@(posedge clock) disable iff (rst)
        !st.regs.pll_down_enable |-> !pll_power_down)
        else $error("pll down although not enabled");
    AST_PLL_OFF_AWAKE: assert property (@(posedge clock) disable iff (rst)
        !low_power |-> !pll_power_down)
        else $error("pll down while not in low power");
    AST_PLL_WITH_SLEEP: assert property (@(posedge clock) disable iff (rst)
        (low_power && energy_detect_power_down && st.regs.pll_down_enable)
        |-> pll_power_down)
        else $error("pll left running in energy-detect sleep");
    AST_SOFT_DOWN_WRITE: assert property (@(posedge clock) disable iff (rst)
        (reg_write && reg_addr == `SGP_OFS_POWER_MODE_CONTROL
         && reg_wdata[`SGP_MODE_LSB +: 2] == `SGP_MODE_SOFT_DOWN) |=> soft_power_down)
        else $error("soft power-down not entered");
    AST_RESERVED_MODE: assert property (@(posedge clock) disable iff (rst)
        (&st.regs.mode) |-> !energy_detect_power_down && !soft_power_down)
        else $error("reserved mode left normal operation");
    AST_NORMAL_MODE: assert property (@(posedge clock) disable iff (rst)
        (st.regs.mode == `SGP_MODE_NORMAL)
        |-> !energy_detect_power_down && !soft_power_down && !pll_power_down)
        else $error("normal mode shows a power-down output");
    AST_FLOW_PASS: assert property (@(posedge clock) disable iff (rst)
        (reg_write && reg_addr == `SGP_OFS_GLOBAL_CONTROL_TEN)
        |=> pass_flow_control == $past(reg_wdata[`SGP_BIT_PASS_FLOW]))
        else $error("pass flow bit not stored");
    AST_EDGE_SELECT: assert property (@(posedge clock) disable iff (rst)
        (reg_write && reg_addr == `SGP_OFS_GLOBAL_CONTROL_NINE)
        |=> read_edge_rising == $past(reg_wdata[`SGP_BIT_READ_EDGE]))
        else $error("edge select not stored");

    AST_SLEEP_RESET: assert property (@(posedge clock)
        rst |=> st.regs.sleep_delay == `SGP_SLEEP_RESET)
        else $error("sleep delay reset value wrong");
    AST_SLEEP_DELAY_WRITE: assert property (@(posedge clock) disable iff (rst)
        (reg_write && reg_addr == `SGP_OFS_SLEEP_DELAY_CONTROL)
        |=> st.regs.sleep_delay == $past(reg_wdata))
        else $error("sleep delay not stored");
    AST_SLEEP_ENTRY: assert property (@(posedge clock) disable iff (rst)
        seq_sleep_entry |-> $past(no_energy) && $past(energy_detect_power_down))
        else $error("low power entered without energy detect and no energy");
    AST_LOW_POWER_NEEDS_MODE: assert property (@(posedge clock) disable iff (rst)
        (low_power && !energy_detect_power_down) |=> !low_power)
        else $error("low power held outside energy detect");
    AST_ENERGY_WAKES: assert property (@(posedge clock) disable iff (rst)
        !no_energy |=> !low_power)
        else $error("low power held with energy present");
endmodule : sgp_switch_global_power_control

// ==== testbench/sgp_host_model.sv ====
// Purpose: host side of the sgp register port
// Assumes: one access at a time, strobe high for a single edge
// Notes: idle address and data show inverted values, never the last access
`timescale 1ns/1ps
module sgp_host_model (
    input  wire logic       clock,
    output logic            reg_write,
    output logic            reg_read,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = 8'hff;
        reg_wdata = 8'h00;
    end
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clock);
        reg_write <= wr;
        reg_read  <= ~wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read  <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        // read data is registered, so it has settled by the falling edge
        @(negedge clock);
        q = reg_rdata;
    endtask : access
endmodule : sgp_host_model

// ==== testbench/sgp_switch_global_power_control_tb_top.sv ====
// Purpose: self-checking bench for the sgp control registers
// Assumes: unit length shortened to UNIT cycles
// Notes: expectations come from a shadow copy of the registers
`timescale 1ns/1ps
module sgp_switch_global_power_control_tb_top;
    localparam int unsigned UNIT = 4;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       reg_write, reg_read, no_energy = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q, a, d;
    logic [2:0] egress_port = 3'h0;
    logic       read_edge_rising, trailer_insert, pass_flow_control, pll_power_down;
    logic       energy_detect_power_down, soft_power_down, low_power;
    logic [7:0] sh [11:15] = '{8'h00, 8'h44, 8'h00, 8'h00, 8'h50};
    int         num_errors = 0;
    int         samples_checked = 0;
    int         n;

    initial forever #25 clock = ~clock;

    sgp_host_model host (.clock(clock), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    sgp_switch_global_power_control #(.UNIT_CYCLES(UNIT)) dut (.clock(clock), .rst(rst),
        .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .egress_port(egress_port),
        .no_energy(no_energy), .read_edge_rising(read_edge_rising),
        .trailer_insert(trailer_insert), .pass_flow_control(pass_flow_control),
        .pll_power_down(pll_power_down), .energy_detect_power_down(energy_detect_power_down),
        .soft_power_down(soft_power_down), .low_power(low_power));

    function automatic logic [7:0] exp_rd(input logic [7:0] ad);
        if (ad >= 8'h0b && ad <= 8'h0f) return sh[ad];
        return 8'h00;
    endfunction : exp_rd

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_flag

    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        host.access(1'b1, ad, dt, q);
        // reserved and read-only bits keep their fixed values
        case (ad)
            8'h0b: sh[11] = dt & 8'h01;
            8'h0c: sh[12] = 8'h44 | (dt & 8'h03);
            8'h0e: sh[14] = dt & 8'h38;
            8'h0f: sh[15] = dt;
            default: ;
        endcase
    endtask : wr

    task automatic rd_check(input logic [7:0] ad);
        host.access(1'b0, ad, 8'h00, q);
        check_reg(q, exp_rd(ad));
        if (ad == 8'h0e) sh[14][4:3] = 2'b00;
    endtask : rd_check

    task automatic measure();
        n = 0;
        while (low_power !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
    endtask : measure

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(50 * 60000);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hdb3839ea));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (int i = 10; i <= 16; i++) rd_check(8'(i));
        $display("test reset values done");
        repeat (24) begin
            a = 8'h0b + 8'($urandom_range(4, 0));
            d = 8'($urandom);
            wr(a, d);
            rd_check(a);
            check_flag(read_edge_rising, sh[11][0]);
            check_flag(pass_flow_control, sh[12][0]);
            for (int p = 0; p < 5; p++) begin
                @(posedge clock);
                egress_port <= 3'(p);
                @(negedge clock);
                check_flag(trailer_insert, sh[12][1] && p == 4);
            end
        end
        $display("test random registers done");
        for (int m = 0; m < 8; m++) begin
            wr(8'h0e, {2'b11, m[2], m[1:0], 3'b111});
            check_flag(energy_detect_power_down, m[1:0] == 2'b01);
            check_flag(soft_power_down, m[1:0] == 2'b10);
            rd_check(8'h0e);
            check_flag(energy_detect_power_down | soft_power_down, 1'b0);
            rd_check(8'h0e);
        end
        $display("test modes done");
        for (int pll = 0; pll < 2; pll++) begin
            d = 8'(1 + $urandom_range(4, 0));
            wr(8'h0f, d);
            wr(8'h0e, {2'b00, pll[0], 2'b01, 3'b000});
            @(posedge clock);
            no_energy <= 1'b1;
            repeat (d * UNIT - 2) @(posedge clock);
            no_energy <= 1'b0;
            @(posedge clock);
            no_energy <= 1'b1;
            // a count that did not restart would sleep after a few cycles
            measure();
            check_flag(n >= d * UNIT - 1 && n <= d * UNIT + 3, 1'b1);
            check_flag(pll_power_down, pll[0]);
            @(posedge clock);
            no_energy <= 1'b0;
            repeat (3) @(negedge clock);
            check_flag(low_power, 1'b0);
            check_flag(pll_power_down, 1'b0);
            rd_check(8'h0e);
        end
        $display("test sleep done");
        tally_and_finish();
    end
endmodule : sgp_switch_global_power_control_tb_top
